//--- pkg/lfdc_pkg.sv
// Package for the linefeed state and DC feed control block: register map,
// field layouts, reset values, the line state encoding and serial port framing.
// Assumes a single 25 MHz clock domain and a host that reaches the registers
// through the serial control port only.
//
// Operation
// RQ1: Eight linefeed states are selectable through the state control register at address 64.
// RQ2: The state field codes are 000 open, 001 forward active, 010 forward on-hook transmission, 011 lead A open, 100 ringing, 101 reverse active, 110 reverse on-hook transmission, 111 lead B open.
// RQ3: The open loop voltage setting is a 6-bit field at address 72, 0 V to 94.5 V in 1.5 V steps, resetting to 48 V.
// RQ4: The current cap setting is a 3-bit field at address 71, 20 mA to 41 mA in 3 mA steps, resetting to 20 mA.
// RQ5: The ground headroom offset is a 6-bit field at address 73 resetting to 3 V, lifting the line away from ground.
// RQ6: The headroom offset goes to the most positive lead, lead A in forward states and lead B in reverse states.
// RQ7: The host programs current cap, open loop voltage and headroom offset before selecting an active state.
// RQ8: In the open state every drive current is off and both leads float.
// RQ9: The block enters the open state by itself when excessive transistor power is reported. The code does so only while auto_open_enable_in is high.
// RQ10: The forward and reverse active states turn the feed on and keep the audio paths off.
// RQ11: The forward and reverse on-hook transmission states turn the audio paths on.
// RQ12: The lead A open state turns off all lead A drive and keeps lead B fed.
// RQ13: The lead B open state turns off the lead B drive and keeps lead A driven.
// RQ14: The ringing state drives the ringing waveform onto both leads.
// RQ15: A host write to the state register sets the state, and an automatic open shows in the readback.

package lfdc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] LINE_STATE_SELECT_ADDR = 7'h40;
  localparam logic [6:0] CURRENT_CAP_SETTING_ADDR = 7'h47;
  localparam logic [6:0] OPEN_LOOP_VOLTAGE_SETTING_ADDR = 7'h48;
  localparam logic [6:0] GROUND_HEADROOM_OFFSET_ADDR = 7'h49;

  // ------------------------------------------------------------------
  // Field layouts and reset values
  // ------------------------------------------------------------------
  localparam int STATE_W = 3;
  localparam int CAP_W = 3;
  localparam int VOLT_W = 6;
  // Cap code 0 is 20 mA; each code adds 3 mA.
  localparam logic [2:0] CURRENT_CAP_RESET = 3'h0;
  // Voltage codes are 1.5 V steps: 48 V is code 32.
  localparam logic [5:0] OPEN_LOOP_VOLTAGE_RESET = 6'h20;
  // 3 V headroom is code 2.
  localparam logic [5:0] GROUND_HEADROOM_RESET = 6'h02;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ------------------------------------------------------------------
  // Line states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    LFDC_OPEN        = 3'h0,
    LFDC_FWD_ACTIVE  = 3'h1,
    LFDC_FWD_ONHOOK  = 3'h2,
    LFDC_LEAD_A_OPEN = 3'h3,
    LFDC_RINGING     = 3'h4,
    LFDC_REV_ACTIVE  = 3'h5,
    LFDC_REV_ONHOOK  = 3'h6,
    LFDC_LEAD_B_OPEN = 3'h7
  } lfdc_line_state_t;

  localparam lfdc_line_state_t LINE_STATE_RESET = LFDC_OPEN;

  // ------------------------------------------------------------------
  // Drive vector bit positions
  // ------------------------------------------------------------------
  localparam int DRV_W = 7;
  localparam int DRV_LEAD_A = 6;
  localparam int DRV_LEAD_B = 5;
  localparam int DRV_FEED = 4;
  localparam int DRV_AUDIO = 3;
  localparam int DRV_RING = 2;
  localparam int DRV_REVERSE = 1;
  localparam int DRV_HEADROOM_A = 0;

  // ------------------------------------------------------------------
  // Serial port framing
  // ------------------------------------------------------------------
  localparam logic [4:0] SPI_CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST_BIT = 5'h0F;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam int SPI_READ_FLAG_POS = 6;

endpackage

//--- rtl/lfdc_spi_port.sv
// Serial control port: synchronises the host pins, frames a command byte
// and a data byte, and issues register writes or shifts out read data.
// Assumes the serial clock runs at most one eighth of clock_in.
`timescale 1ns/10ps

module lfdc_spi_port (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  input wire logic [7:0] rd_data_in,
  output logic [6:0] addr_out,
  output logic wr_stb_out,
  output logic [7:0] wr_data_out,
  output logic sdo_out,
  output logic sdo_oe_n_out
);

  logic [1:0] sclk_s_r;
  logic [1:0] cs_s_r;
  logic [1:0] sdi_s_r;
  logic sclk_d_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic is_read_r;
  logic load_r;
  logic active;
  logic rise;
  logic fall;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Only the second stage is looked at, so a metastable first stage never leaks.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      sdi_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else if (clk_en_in) begin
      sclk_s_r <= {sclk_s_r[0], spi_sclk_in};
      cs_s_r <= {cs_s_r[0], spi_cs_n_in};
      sdi_s_r <= {sdi_s_r[0], spi_sdi_in};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  assign active = ~cs_s_r[1];
  assign rise = active & sclk_s_r[1] & ~sclk_d_r;
  assign fall = active & ~sclk_s_r[1] & sclk_d_r;

  // ------------------------------------------------------------------
  // Receive framing
  // ------------------------------------------------------------------
  // Bits beyond the sixteenth are ignored until select is released.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 8'h00;
      addr_out <= 7'h00;
      is_read_r <= 1'b0;
      load_r <= 1'b0;
      wr_stb_out <= 1'b0;
      wr_data_out <= 8'h00;
    end else if (clk_en_in) begin
      load_r <= 1'b0;
      wr_stb_out <= 1'b0;
      if (!active) begin
        bit_cnt_r <= 5'h00;
      end else if (rise && bit_cnt_r != lfdc_pkg::SPI_FRAME_BITS) begin
        shift_r <= {shift_r[6:0], sdi_s_r[1]};
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == lfdc_pkg::SPI_CMD_LAST_BIT) begin
          addr_out <= {shift_r[5:0], sdi_s_r[1]};
          is_read_r <= shift_r[lfdc_pkg::SPI_READ_FLAG_POS];
          load_r <= 1'b1;
        end
        if (bit_cnt_r == lfdc_pkg::SPI_FRAME_LAST_BIT && !is_read_r) begin
          wr_data_out <= {shift_r[6:0], sdi_s_r[1]};
          wr_stb_out <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit path
  // ------------------------------------------------------------------
  // Read data is loaded the cycle after the command, well before the next falling edge.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_r <= 8'h00;
      sdo_out <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      sdo_oe_n_out <= ~(active & is_read_r & bit_cnt_r[3]);
      if (load_r) begin
        tx_r <= is_read_r ? rd_data_in : 8'h00;
      end else if (fall && bit_cnt_r[3]) begin
        sdo_out <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

endmodule

//--- rtl/lfdc_linefeed_ctrl.sv
// Linefeed state and DC feed control: register bank behind the serial port,
// the line state selector, drive gating for the external transistors and the
// automatic fall back to the open state on a power alarm.
// Assumes power_alarm_in and auto_open_enable_in come from logic on clock_in.
`timescale 1ns/10ps

module lfdc_linefeed_ctrl (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  input wire logic power_alarm_in,
  input wire logic auto_open_enable_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_n_out,
  output logic lead_a_drive_en_out,
  output logic lead_b_drive_en_out,
  output logic feed_en_out,
  output logic audio_path_en_out,
  output logic ringing_drive_en_out,
  output logic polarity_reverse_out,
  output logic headroom_on_lead_a_out,
  output logic auto_open_event_out,
  output logic [2:0] current_cap_setting_out,
  output logic [5:0] open_loop_voltage_setting_out,
  output logic [5:0] ground_headroom_offset_out
);

  lfdc_pkg::lfdc_line_state_t state_r;
  logic [2:0] current_cap_r;
  logic [5:0] open_loop_voltage_r;
  logic [5:0] ground_headroom_r;
  logic [6:0] reg_addr;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic force_open;
  logic [lfdc_pkg::DRV_W-1:0] drive_nxt;

  // ------------------------------------------------------------------
  // Drive decode
  // ------------------------------------------------------------------
  // Maps a line state to the drive vector for the registered outputs; the checks below decode state_r on their own.
  function automatic logic [lfdc_pkg::DRV_W-1:0] drive_of(
      input lfdc_pkg::lfdc_line_state_t st);
    logic [lfdc_pkg::DRV_W-1:0] v;
    v = '0;
    case (st)
      lfdc_pkg::LFDC_FWD_ACTIVE, lfdc_pkg::LFDC_REV_ACTIVE: begin
        v[lfdc_pkg::DRV_LEAD_A] = 1'b1; // RQ10
        v[lfdc_pkg::DRV_LEAD_B] = 1'b1;
        v[lfdc_pkg::DRV_FEED] = 1'b1;
      end
      lfdc_pkg::LFDC_FWD_ONHOOK, lfdc_pkg::LFDC_REV_ONHOOK: begin
        v[lfdc_pkg::DRV_LEAD_A] = 1'b1; // RQ11
        v[lfdc_pkg::DRV_LEAD_B] = 1'b1;
        v[lfdc_pkg::DRV_FEED] = 1'b1;
        v[lfdc_pkg::DRV_AUDIO] = 1'b1;
      end
      lfdc_pkg::LFDC_LEAD_A_OPEN: begin
        v[lfdc_pkg::DRV_LEAD_B] = 1'b1; // RQ12
        v[lfdc_pkg::DRV_FEED] = 1'b1;
      end
      lfdc_pkg::LFDC_LEAD_B_OPEN: begin
        v[lfdc_pkg::DRV_LEAD_A] = 1'b1; // RQ13
        v[lfdc_pkg::DRV_FEED] = 1'b1;
      end
      lfdc_pkg::LFDC_RINGING: begin
        v[lfdc_pkg::DRV_LEAD_A] = 1'b1; // RQ14
        v[lfdc_pkg::DRV_LEAD_B] = 1'b1;
        v[lfdc_pkg::DRV_RING] = 1'b1;
      end
      default: begin
        v = '0; // RQ8
      end
    endcase
    // Reverse states put the positive lead, and so the headroom, on lead B.
    v[lfdc_pkg::DRV_REVERSE] = (st == lfdc_pkg::LFDC_REV_ACTIVE) ||
                               (st == lfdc_pkg::LFDC_REV_ONHOOK); // RQ6
    v[lfdc_pkg::DRV_HEADROOM_A] = ~v[lfdc_pkg::DRV_REVERSE]; // RQ6
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Serial control port
  // ------------------------------------------------------------------
  lfdc_spi_port u_spi (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .spi_sclk_in(spi_sclk_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_sdi_in(spi_sdi_in),
    .rd_data_in(rd_data),
    .addr_out(reg_addr),
    .wr_stb_out(wr_stb),
    .wr_data_out(wr_data),
    .sdo_out(spi_sdo_out),
    .sdo_oe_n_out(spi_sdo_oe_n_out)
  );

  // ------------------------------------------------------------------
  // Line state selector
  // ------------------------------------------------------------------
  // The alarm wins over a host write in the same cycle, so a fault can never
  // be overridden by a late write while the transistors are overheating.
  assign force_open = power_alarm_in & auto_open_enable_in; // RQ9

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= lfdc_pkg::LINE_STATE_RESET;
    end else if (clk_en_in) begin
      if (force_open) begin
        state_r <= lfdc_pkg::LFDC_OPEN; // RQ9
      end else if (wr_stb && reg_addr == lfdc_pkg::LINE_STATE_SELECT_ADDR) begin
        state_r <= lfdc_pkg::lfdc_line_state_t'(wr_data[2:0]); // RQ1 RQ2 RQ15
      end
    end
  end

  // ------------------------------------------------------------------
  // DC feed settings
  // ------------------------------------------------------------------
  // Settings reset to usable defaults, so an early active state is still safe.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      current_cap_r <= lfdc_pkg::CURRENT_CAP_RESET; // RQ4
      open_loop_voltage_r <= lfdc_pkg::OPEN_LOOP_VOLTAGE_RESET; // RQ3
      ground_headroom_r <= lfdc_pkg::GROUND_HEADROOM_RESET; // RQ5
    end else if (clk_en_in && wr_stb) begin
      if (reg_addr == lfdc_pkg::CURRENT_CAP_SETTING_ADDR) begin
        current_cap_r <= wr_data[2:0]; // RQ4
      end else if (reg_addr == lfdc_pkg::OPEN_LOOP_VOLTAGE_SETTING_ADDR) begin
        open_loop_voltage_r <= wr_data[5:0]; // RQ3
      end else if (reg_addr == lfdc_pkg::GROUND_HEADROOM_OFFSET_ADDR) begin
        ground_headroom_r <= wr_data[5:0]; // RQ5
      end
    end
  end

  // ------------------------------------------------------------------
  // Read-back mux
  // ------------------------------------------------------------------
  // The state read back is the live one, including any automatic open.
  always_comb begin
    if (reg_addr == lfdc_pkg::LINE_STATE_SELECT_ADDR) begin
      rd_data = {5'h00, state_r}; // RQ15
    end else if (reg_addr == lfdc_pkg::CURRENT_CAP_SETTING_ADDR) begin
      rd_data = {5'h00, current_cap_r};
    end else if (reg_addr == lfdc_pkg::OPEN_LOOP_VOLTAGE_SETTING_ADDR) begin
      rd_data = {2'h0, open_loop_voltage_r};
    end else if (reg_addr == lfdc_pkg::GROUND_HEADROOM_OFFSET_ADDR) begin
      rd_data = {2'h0, ground_headroom_r};
    end else begin
      rd_data = lfdc_pkg::UNMAPPED_READ_VALUE;
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  // Every drive follows the state one cycle later; settings follow the registers.
  assign drive_nxt = drive_of(state_r);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lead_a_drive_en_out <= 1'b0;
      lead_b_drive_en_out <= 1'b0;
      feed_en_out <= 1'b0;
      audio_path_en_out <= 1'b0;
      ringing_drive_en_out <= 1'b0;
      polarity_reverse_out <= 1'b0;
      headroom_on_lead_a_out <= 1'b1;
    end else if (clk_en_in) begin
      lead_a_drive_en_out <= drive_nxt[lfdc_pkg::DRV_LEAD_A]; // RQ8
      lead_b_drive_en_out <= drive_nxt[lfdc_pkg::DRV_LEAD_B]; // RQ8
      feed_en_out <= drive_nxt[lfdc_pkg::DRV_FEED]; // RQ10
      audio_path_en_out <= drive_nxt[lfdc_pkg::DRV_AUDIO]; // RQ11
      ringing_drive_en_out <= drive_nxt[lfdc_pkg::DRV_RING]; // RQ14
      polarity_reverse_out <= drive_nxt[lfdc_pkg::DRV_REVERSE];
      headroom_on_lead_a_out <= drive_nxt[lfdc_pkg::DRV_HEADROOM_A]; // RQ6
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      current_cap_setting_out <= lfdc_pkg::CURRENT_CAP_RESET;
      open_loop_voltage_setting_out <= lfdc_pkg::OPEN_LOOP_VOLTAGE_RESET;
      ground_headroom_offset_out <= lfdc_pkg::GROUND_HEADROOM_RESET;
    end else if (clk_en_in) begin
      current_cap_setting_out <= current_cap_r; // RQ4
      open_loop_voltage_setting_out <= open_loop_voltage_r; // RQ3
      ground_headroom_offset_out <= ground_headroom_r; // RQ5
    end
  end

  // A one-cycle mark each time the alarm actually drops a live state to open.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      auto_open_event_out <= 1'b0;
    end else if (clk_en_in) begin
      auto_open_event_out <= force_open && (state_r != lfdc_pkg::LFDC_OPEN); // RQ9
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking chk_cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_alarm_hit;
    clk_en_in && force_open;
  endsequence

  sequence s_alarm_then_run;
    s_alarm_hit ##1 clk_en_in;
  endsequence

  chk_auto_open_state: assert property (s_alarm_hit |=> state_r == lfdc_pkg::LFDC_OPEN) // RQ9
    else $error("Power alarm did not force the open state.");

  chk_auto_open_drive: assert property (s_alarm_then_run |=> // RQ8
      !lead_a_drive_en_out && !lead_b_drive_en_out && !feed_en_out && !ringing_drive_en_out)
    else $error("Drives still on after an automatic open.");

  chk_state_write_takes: assert property (clk_en_in && wr_stb && !force_open && // RQ15
      reg_addr == lfdc_pkg::LINE_STATE_SELECT_ADDR |=> state_r == $past(wr_data[2:0]))
    else $error("Host write to the state register was not taken.");

  chk_active_audio_off: assert property (clk_en_in && // RQ10
      (state_r == lfdc_pkg::LFDC_FWD_ACTIVE || state_r == lfdc_pkg::LFDC_REV_ACTIVE)
      |=> feed_en_out && !audio_path_en_out)
    else $error("Active state must feed with audio off.");

  chk_onhook_audio_on: assert property (clk_en_in && // RQ11
      (state_r == lfdc_pkg::LFDC_FWD_ONHOOK || state_r == lfdc_pkg::LFDC_REV_ONHOOK)
      |=> audio_path_en_out && lead_a_drive_en_out && lead_b_drive_en_out)
    else $error("On-hook transmission state must enable audio.");

  chk_lead_a_open: assert property (clk_en_in && // RQ12
      state_r == lfdc_pkg::LFDC_LEAD_A_OPEN |=> !lead_a_drive_en_out && lead_b_drive_en_out)
    else $error("Lead A open state drives the wrong lead.");

  chk_lead_b_open: assert property (clk_en_in && // RQ13
      state_r == lfdc_pkg::LFDC_LEAD_B_OPEN |=> lead_a_drive_en_out && !lead_b_drive_en_out)
    else $error("Lead B open state drives the wrong lead.");

  chk_ringing_drive: assert property (clk_en_in && // RQ14
      state_r == lfdc_pkg::LFDC_RINGING |=> ringing_drive_en_out && !audio_path_en_out)
    else $error("Ringing state does not drive the ringing waveform.");

  chk_headroom_lead: assert property (clk_en_in |=> headroom_on_lead_a_out != // RQ6
      ($past(state_r) inside {lfdc_pkg::LFDC_REV_ACTIVE, lfdc_pkg::LFDC_REV_ONHOOK}))
    else $error("Headroom offset sits on the wrong lead.");

endmodule

//--- test/lfdc_host_model.sv
// Host model for the serial control port: one select frame carries a
// command byte and a data byte, and read data is captured on the way.
// Assumes the block samples on rising serial edges and shifts on falling.
`timescale 1ns/10ps

module lfdc_host_model (
  input wire logic clock_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  // Half a serial period in system clocks; six leaves margin over the
  // four that the block's synchronisers need.
  localparam int HALF = 6;

  // The serial clock rests low and the select rests high outside frames.
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // Waits whole system clocks and lands on a falling edge.
  task automatic pause(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // Bit 7 of cmd is the read flag. A bit taken while the block does not
  // drive the data line reads as unknown, so a silent read cannot pass.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {cmd, wdata};
    rdata = 8'h00;
    cs_n_out = 1'b0;
    pause(HALF);
    for (int i = 15; i >= 0; i--) begin
      sdi_out = frame[i];
      pause(HALF);
      if (i < 8) begin
        rdata[i] = (sdo_oe_n_in === 1'b0) ? sdo_in : 1'bx;
      end
      sclk_out = 1'b1;
      pause(HALF);
      sclk_out = 1'b0;
    end
    pause(HALF);
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line shows no stale bit.
    pause(HALF);
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the linefeed state and DC feed control block.
// Assumes the host model frames serial traffic and inputs change on falling edges.
`timescale 1ns/10ps

module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_in, reset_n_in, clk_en_in, power_alarm_in, auto_open_enable_in;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, lead_a, lead_b, feed, audio, ring, rev, hd_a, evt;
  logic [2:0] cap;
  logic [5:0] volt, hdr;
  logic [6:0] drv;
  logic [7:0] rd;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam int LIMIT = 20000;
  // Expected drive vector and the bits each state defines, by state code.
  logic [6:0] exp_t [8] = '{7'h00, 7'h71, 7'h79, 7'h30, 7'h64, 7'h72, 7'h7A, 7'h50};
  logic [6:0] msk_t [8] = '{7'h7C, 7'h7F, 7'h7F, 7'h70, 7'h74, 7'h7F, 7'h7F, 7'h70};

  // Drive outputs gathered in the package's bit order.
  assign drv = {lead_a, lead_b, feed, audio, ring, rev, hd_a};

  lfdc_linefeed_ctrl i_lfdc_linefeed_ctrl (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi),
    .power_alarm_in(power_alarm_in), .auto_open_enable_in(auto_open_enable_in),
    .spi_sdo_out(sdo), .spi_sdo_oe_n_out(sdo_oe_n), .lead_a_drive_en_out(lead_a),
    .lead_b_drive_en_out(lead_b), .feed_en_out(feed), .audio_path_en_out(audio),
    .ringing_drive_en_out(ring), .polarity_reverse_out(rev), .headroom_on_lead_a_out(hd_a),
    .auto_open_event_out(evt), .current_cap_setting_out(cap),
    .open_loop_voltage_setting_out(volt), .ground_headroom_offset_out(hdr));

  lfdc_host_model i_lfdc_host_model (.clock_in(clock_in), .sdo_in(sdo),
    .sdo_oe_n_in(sdo_oe_n), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A write lands a few clocks after the last rising serial edge; eight covers it.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_lfdc_host_model.xfer({1'b0, a}, d, rd);
    repeat (8) @(negedge clock_in);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    i_lfdc_host_model.xfer({1'b1, a}, 8'hA5, rd);
    check(what, exp, rd);
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("cap out", 8'h00, {5'h0, cap});
    check("voltage out", 8'h20, {2'h0, volt});
    check("headroom out", 8'h02, {2'h0, hdr});
    check("drive", 8'h01, {1'b0, drv});
    rd_chk("state reg", lfdc_pkg::LINE_STATE_SELECT_ADDR, 8'h00);
    rd_chk("cap reg", lfdc_pkg::CURRENT_CAP_SETTING_ADDR, 8'h00);
    rd_chk("voltage reg", lfdc_pkg::OPEN_LOOP_VOLTAGE_SETTING_ADDR, 8'h20);
    rd_chk("headroom reg", lfdc_pkg::GROUND_HEADROOM_OFFSET_ADDR, 8'h02);
  endtask

  // Settings go in before any active state; upper bits are not stored.
  task automatic t_settings;
    wr(lfdc_pkg::CURRENT_CAP_SETTING_ADDR, 8'hFF);
    wr(lfdc_pkg::OPEN_LOOP_VOLTAGE_SETTING_ADDR, 8'hFF);
    wr(lfdc_pkg::GROUND_HEADROOM_OFFSET_ADDR, 8'h05);
    check("cap out", 8'h07, {5'h0, cap});
    check("voltage out", 8'h3F, {2'h0, volt});
    check("headroom out", 8'h05, {2'h0, hdr});
    check("drive", 8'h01, {1'b0, drv});
    rd_chk("cap reg", lfdc_pkg::CURRENT_CAP_SETTING_ADDR, 8'h07);
    rd_chk("voltage reg", lfdc_pkg::OPEN_LOOP_VOLTAGE_SETTING_ADDR, 8'h3F);
    rd_chk("headroom reg", lfdc_pkg::GROUND_HEADROOM_OFFSET_ADDR, 8'h05);
    wr(7'h41, 8'h5A);
    rd_chk("unmapped reg", 7'h41, 8'h00);
  endtask

  // Every state code in turn, ending back in open after the lead-B-open state.
  task automatic t_states;
    logic [2:0] st;
    for (int s = 1; s <= 8; s++) begin
      st = 3'(s);
      wr(lfdc_pkg::LINE_STATE_SELECT_ADDR, {5'h0, st});
      check("drive", {1'b0, exp_t[st] & msk_t[st]}, {1'b0, drv & msk_t[st]});
      check("headroom lead", {7'h0, !(st == 3'h5 || st == 3'h6)}, {7'h0, hd_a});
      check("polarity", {7'h0, (st == 3'h5 || st == 3'h6)}, {7'h0, rev});
      rd_chk("state reg", lfdc_pkg::LINE_STATE_SELECT_ADDR, {5'h0, st});
    end
  endtask

  task automatic t_auto_open;
    wr(lfdc_pkg::LINE_STATE_SELECT_ADDR, 8'h05);
    power_alarm_in = 1'b1;
    repeat (3) @(negedge clock_in);
    check("drive", 8'h72, {1'b0, drv});
    auto_open_enable_in = 1'b1;
    @(negedge clock_in);
    power_alarm_in = 1'b0;
    check("open event", 8'h01, {7'h0, evt});
    @(negedge clock_in);
    check("open event", 8'h00, {7'h0, evt});
    check("drive", 8'h00, {1'b0, drv & 7'h7C});
    rd_chk("state reg", lfdc_pkg::LINE_STATE_SELECT_ADDR, 8'h00);
    // A standing alarm keeps the line open against host writes.
    power_alarm_in = 1'b1;
    wr(lfdc_pkg::LINE_STATE_SELECT_ADDR, 8'h01);
    check("open event", 8'h00, {7'h0, evt});
    rd_chk("state reg", lfdc_pkg::LINE_STATE_SELECT_ADDR, 8'h00);
    power_alarm_in = 1'b0;
    wr(lfdc_pkg::LINE_STATE_SELECT_ADDR, 8'h01);
    check("drive", 8'h71, {1'b0, drv});
    auto_open_enable_in = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Reset is released on a falling edge so the release is clean at the next rise.
  initial begin
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    power_alarm_in = 1'b0;
    auto_open_enable_in = 1'b0;
    repeat (5) @(negedge clock_in);
    reset_n_in = 1'b1;
    repeat (3) @(negedge clock_in);
    t_reset();
    t_settings();
    t_states();
    t_auto_open();
    stop_test();
  end

  // Some thirty-three frames of about two hundred and ten clocks each fit well under the ceiling.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end
endmodule
